// *** motion_ctrl_map.svh ***
// Constants for the motion output controller: offsets, codes and timing counts.
// Assumes a 10 MHz core clock; included by bare name.
`ifndef MOTION_CTRL_MAP_SVH
`define MOTION_CTRL_MAP_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_HZ             10000000
`define STABLE_WAIT_S      20
`define STABLE_WAIT_CYC    (`STABLE_WAIT_S * `CLK_HZ)
`define SAMPLE_PERIOD_MS   10
`define SAMPLE_PERIOD_CYC  ((`SAMPLE_PERIOD_MS * `CLK_HZ) / 1000)
`define UART_BAUD          9600
`define UART_BIT_CYC       (`CLK_HZ / `UART_BAUD)
`define UART_HALF_CYC      (`UART_BIT_CYC / 2)

// ----------------------------------------
// Hold times in seconds, one per hold step
// ----------------------------------------
`define HOLD_S_0           2
`define HOLD_S_1           5
`define HOLD_S_2           10
`define HOLD_S_3           30
`define HOLD_S_4           60
`define HOLD_S_5           120
`define HOLD_S_6           180
`define HOLD_S_7           300
`define HOLD_S_8           600
`define HOLD_S_9           900
`define HOLD_STEPS         10

// ----------------------------------------
// Analog code thresholds on 8-bit converter results (full scale 3.3 V)
// ----------------------------------------
`define CODE_1V8           8'h8B
`define CODE_2V5           8'hC2
`define CODE_1V0           8'h4D
`define HOLD_CODE_STEP     8'h0F

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define REG_CTRL           4'h0
`define REG_LIGHT_THR      4'h1
`define REG_STATUS         4'h2
`define REG_SENS           4'h3
`define REG_HOLD_SEL       4'h4
`define REG_RX_DATA        4'h5
`define REG_TX_DATA        4'h6
`define LIGHT_THR_RST      8'h64
`define CTRL_RST           8'h00
`define CTRL_PIN_MOTION    0

`endif

// *** motion_ctrl_pkg.sv ***
// Types shared by the motion output controller files.
// Assumes nothing beyond the map header.
package motion_ctrl_pkg;
  typedef enum logic [3:0] {
    ST_WAIT_STABLE = 4'h1,
    ST_RUN         = 4'h2,
    ST_SLEEP       = 4'h4,
    ST_RESAMPLE    = 4'h8
  } ctrl_state_t;
  typedef logic [7:0] code_t;
endpackage

// *** sync2.sv ***
// Two-flop synchroniser for one input level.
// Assumes the input comes from outside the core_clk domain.
`timescale 1ns/100ps
module sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// *** motion_output_controller.sv ***
// Motion output controller: mode select, hold timer, light gate, sleep, reset sequencing and serial link.
// Assumes analog inputs arrive as 8-bit converter codes and motion events from a detector on core_clk.
`timescale 1ns/100ps
`include "motion_ctrl_map.svh"

// Summary of operation
// R1 - Low sensitivity voltage means highest sensitivity.
// R2 - Sample mode pin at power-on and wake.
// R3 - Motion output low when active, else high.
// R4 - Hold output active for selected time.
// R5 - Hardware mode: dark light level blocks activation.
// R6 - Active output finishes hold despite gate.
// R7 - Serial mode: light must exceed programmed threshold.
// R8 - Serial mode: threshold crossing lets hold finish.
// R9 - Sleep input low stops detection, output inactive.
// R10 - Host keeps sleep input high at power-on.
// R11 - Serial link 9600 baud, 8N1, no flow.
// R12 - Serial mode pin: motion output or reset.
// R13 - Supply droop holds reset, repeats power-on.
// R14 - Wait for sensor stable before detection.
// R15 - Hardware mode resamples analog inputs periodically.
// R16 - Serial mode keeps light, sleep, motion working.
// R17 - Hold input maps to ten durations.
// R18 - Serial mode: received character wakes device.
// R19 - New detection restarts the hold timer.
// R20 - Mode stays latched until next sample.
module motion_output_controller #(
  parameter int STABLE_CYC = `STABLE_WAIT_CYC,
  parameter int SAMPLE_CYC = `SAMPLE_PERIOD_CYC,
  parameter int SEC_CYC    = `CLK_HZ
) (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 supply_droop_reset,
  input  wire logic                 sleep_request_n,
  input  wire motion_ctrl_pkg::code_t mode_sense_in,
  input  wire motion_ctrl_pkg::code_t sensitivity_in,
  input  wire motion_ctrl_pkg::code_t hold_time_in,
  input  wire motion_ctrl_pkg::code_t light_level_in,
  input  wire logic                 motion_event,
  input  wire logic                 rxd_in,
  output logic                      txd_out,
  output logic                      txd_oe,
  input  wire logic                 motion_flag_n_in,
  output logic                      motion_flag_n,
  output logic                      motion_flag_oe,
  output logic                      module_reset_req,
  output motion_ctrl_pkg::code_t    sensitivity_level,
  output logic                      serial_mode,
  output logic                      detect_enable,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata
);
  import motion_ctrl_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic sleep_n_s;
  logic droop_s;
  logic rxd_s;
  logic md_in_s;
  sync2 #(.RST_VAL(1'b1)) u_sync_sleep (.core_clk(core_clk), .sys_rst(sys_rst),
    .async_in(sleep_request_n), .sync_out(sleep_n_s));
  sync2 #(.RST_VAL(1'b0)) u_sync_droop (.core_clk(core_clk), .sys_rst(sys_rst),
    .async_in(supply_droop_reset), .sync_out(droop_s));
  sync2 #(.RST_VAL(1'b1)) u_sync_rxd (.core_clk(core_clk), .sys_rst(sys_rst),
    .async_in(rxd_in), .sync_out(rxd_s));
  sync2 #(.RST_VAL(1'b1)) u_sync_md (.core_clk(core_clk), .sys_rst(sys_rst),
    .async_in(motion_flag_n_in), .sync_out(md_in_s));

  // ----------------------------------------
  // Control state and mode latch
  // ----------------------------------------
  ctrl_state_t state_q;
  ctrl_state_t state_d;
  logic [31:0] stab_cnt_q;
  logic        serial_q;
  logic        rx_start;
  logic        rst_all;
  logic        stable_done;

  assign rst_all     = sys_rst | droop_s;                                      // R13
  assign stable_done = (stab_cnt_q >= 32'(STABLE_CYC - 1));
  assign rx_start    = serial_q & ~rxd_s;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_WAIT_STABLE: if (stable_done) state_d = ST_RUN;                       // R14
      ST_RUN:         if (!sleep_n_s) state_d = ST_SLEEP;                      // R9
      ST_SLEEP:       if (sleep_n_s || rx_start) state_d = ST_RESAMPLE;        // R18
      ST_RESAMPLE:    state_d = ST_RUN;
      default:        state_d = ST_WAIT_STABLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      state_q    <= ST_WAIT_STABLE;                                            // R13
      stab_cnt_q <= 32'h0000_0000;
    end else begin
      state_q    <= state_d;
      stab_cnt_q <= stable_done ? stab_cnt_q : stab_cnt_q + 32'h0000_0001;
    end
  end

  // Mode is caught after reset release and on wake, then held.
  logic mode_pending_q;
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      mode_pending_q <= 1'b1;
      serial_q       <= 1'b0;
    end else begin
      mode_pending_q <= 1'b0;
      if (mode_pending_q || state_q == ST_RESAMPLE) begin
        serial_q <= (mode_sense_in > `CODE_2V5);                               // R2 R20
      end
    end
  end
  assign serial_mode = serial_q;

  // ----------------------------------------
  // Periodic sampling of analog inputs
  // ----------------------------------------
  logic [31:0] samp_cnt_q;
  logic        samp_tick;
  code_t       sens_q;
  code_t       hold_q;
  code_t       light_q;
  assign samp_tick = (samp_cnt_q >= 32'(SAMPLE_CYC - 1));
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      samp_cnt_q <= 32'h0000_0000;
      sens_q     <= 8'hFF;
      hold_q     <= 8'h00;
      light_q    <= 8'hFF;
    end else begin
      samp_cnt_q <= samp_tick ? 32'h0000_0000 : samp_cnt_q + 32'h0000_0001;
      if (samp_tick) begin                                                     // R15
        sens_q  <= sensitivity_in;
        hold_q  <= hold_time_in;
        light_q <= light_level_in;
      end
    end
  end

  // Inverse sensitivity, clipped at the top of the range.
  code_t sens_clip;
  assign sens_clip = (sens_q > `CODE_1V8) ? `CODE_1V8 : sens_q;
  always_ff @(posedge core_clk) begin
    if (rst_all) sensitivity_level <= 8'h00;
    else         sensitivity_level <= 8'(`CODE_1V8 - sens_clip);               // R1
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  code_t ctrl_q;
  code_t light_thr_q;
  code_t hold_sel_q;
  code_t rx_data_q;
  logic  tx_start;
  logic  tx_busy;
  logic  rx_valid;
  code_t rx_byte;
  logic  pin_motion;
  assign pin_motion = ctrl_q[`CTRL_PIN_MOTION];
  assign tx_start   = reg_wr & (reg_addr == `REG_TX_DATA) & serial_q & ~tx_busy;
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      ctrl_q      <= `CTRL_RST;                                                // R12
      light_thr_q <= `LIGHT_THR_RST;
      hold_sel_q  <= 8'h00;
      rx_data_q   <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `REG_CTRL)      ctrl_q      <= reg_wdata;
      if (reg_wr && reg_addr == `REG_LIGHT_THR) light_thr_q <= reg_wdata;
      if (reg_wr && reg_addr == `REG_HOLD_SEL)  hold_sel_q  <= reg_wdata;
      if (rx_valid)                             rx_data_q   <= rx_byte;
    end
  end

  logic [7:0] rd_mux;
  assign rd_mux = (reg_addr == `REG_CTRL)      ? ctrl_q :
                  (reg_addr == `REG_LIGHT_THR) ? light_thr_q :
                  (reg_addr == `REG_STATUS)    ? {3'h0, tx_busy, state_q} :
                  (reg_addr == `REG_SENS)      ? sensitivity_level :
                  (reg_addr == `REG_HOLD_SEL)  ? hold_sel_q :
                  (reg_addr == `REG_RX_DATA)   ? rx_data_q : 8'h00;
  always_ff @(posedge core_clk) begin
    if (rst_all)     reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_mux;
    else             reg_rdata <= 8'h00;
  end

  // ----------------------------------------
  // Hold time selection and light gate
  // ----------------------------------------
  logic [3:0]  hold_idx;
  logic [3:0]  hw_idx;
  logic [31:0] hold_sec;
  logic        light_ok;
  assign hw_idx   = (hold_q / `HOLD_CODE_STEP > 8'h09) ? 4'h9 : 4'(hold_q / `HOLD_CODE_STEP);
  assign hold_idx = serial_q ? ((hold_sel_q > 8'h09) ? 4'h9 : hold_sel_q[3:0]) : hw_idx;
  always_comb begin
    case (hold_idx)                                                            // R17
      4'h0:    hold_sec = `HOLD_S_0;
      4'h1:    hold_sec = `HOLD_S_1;
      4'h2:    hold_sec = `HOLD_S_2;
      4'h3:    hold_sec = `HOLD_S_3;
      4'h4:    hold_sec = `HOLD_S_4;
      4'h5:    hold_sec = `HOLD_S_5;
      4'h6:    hold_sec = `HOLD_S_6;
      4'h7:    hold_sec = `HOLD_S_7;
      4'h8:    hold_sec = `HOLD_S_8;
      default: hold_sec = `HOLD_S_9;
    endcase
  end
  assign light_ok = serial_q ? (light_q > light_thr_q)                         // R7
                             : (light_q >= `CODE_1V0);                         // R5

  // ----------------------------------------
  // Hold timer
  // ----------------------------------------
  logic        active_q;
  logic [31:0] sec_cnt_q;
  logic [31:0] hold_left_q;
  logic        run;
  logic        trigger;
  logic        sec_tick;
  assign run         = (state_q == ST_RUN);
  assign detect_enable = run;                                                  // R9 R14
  assign trigger     = run & motion_event & (light_ok | active_q);             // R5 R7 R19
  assign sec_tick    = (sec_cnt_q >= 32'(SEC_CYC - 1));
  always_ff @(posedge core_clk) begin
    if (rst_all || !run) begin
      active_q    <= 1'b0;                                                     // R9 R14
      sec_cnt_q   <= 32'h0000_0000;
      hold_left_q <= 32'h0000_0000;
    end else if (trigger) begin
      active_q    <= 1'b1;                                                     // R4 R19
      sec_cnt_q   <= 32'h0000_0000;
      hold_left_q <= hold_sec;
    end else if (active_q) begin
      sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
      if (sec_tick) begin                                                      // R6 R8
        hold_left_q <= hold_left_q - 32'h0000_0001;
        if (hold_left_q == 32'h0000_0001) active_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Motion pin: output, or reset input in serial mode
  // ----------------------------------------
  logic pin_is_reset;
  assign pin_is_reset = serial_q & ~pin_motion;                                // R12 R16
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      motion_flag_n    <= 1'b1;
      motion_flag_oe   <= 1'b1;
      module_reset_req <= 1'b0;
    end else begin
      motion_flag_n    <= ~active_q;                                           // R3
      motion_flag_oe   <= ~pin_is_reset;                                       // R3
      module_reset_req <= pin_is_reset & ~md_in_s;                             // R12
    end
  end

  // ----------------------------------------
  // Serial link, 8N1
  // ----------------------------------------
  logic [15:0] rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic [7:0]  rx_sh_q;
  logic        rx_busy_q;
  assign rx_valid = rx_busy_q & (rx_bit_q == 4'h9) & (rx_cnt_q == 16'h0000) & rxd_s;
  assign rx_byte  = rx_sh_q;
  always_ff @(posedge core_clk) begin
    if (rst_all || !serial_q) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= 16'h0000;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
    end else if (!rx_busy_q) begin
      if (!rxd_s) begin                                                        // R11 R18
        rx_busy_q <= 1'b1;
        rx_cnt_q  <= 16'(`UART_HALF_CYC);
        rx_bit_q  <= 4'h0;
      end
    end else if (rx_cnt_q != 16'h0000) begin
      rx_cnt_q <= rx_cnt_q - 16'h0001;
    end else begin
      rx_cnt_q <= 16'(`UART_BIT_CYC - 1);
      rx_bit_q <= rx_bit_q + 4'h1;
      if (rx_bit_q == 4'h0 && rxd_s) rx_busy_q <= 1'b0;
      if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8) rx_sh_q <= {rxd_s, rx_sh_q[7:1]};
      if (rx_bit_q == 4'h9) rx_busy_q <= 1'b0;
    end
  end

  logic [15:0] tx_cnt_q;
  logic [3:0]  tx_bit_q;
  logic [9:0]  tx_sh_q;
  assign tx_busy = (tx_bit_q != 4'h0);
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      tx_cnt_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      tx_sh_q  <= 10'h3FF;
    end else if (tx_start) begin                                               // R11
      tx_sh_q  <= {1'b1, reg_wdata, 1'b0};
      tx_bit_q <= 4'hA;
      tx_cnt_q <= 16'(`UART_BIT_CYC - 1);
    end else if (tx_busy) begin
      if (tx_cnt_q != 16'h0000) begin
        tx_cnt_q <= tx_cnt_q - 16'h0001;
      end else begin
        tx_cnt_q <= 16'(`UART_BIT_CYC - 1);
        tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
        tx_bit_q <= tx_bit_q - 4'h1;
      end
    end
  end
  assign txd_out = tx_sh_q[0];
  assign txd_oe  = serial_q;                                                   // R16
endmodule

// *** motion_ctrl_asserts.sv ***
// Concurrent checks on the ports of the motion output controller.
// Assumes a bind onto motion_output_controller and the map header.
`timescale 1ns/100ps
`include "motion_ctrl_map.svh"
module motion_ctrl_asserts #(
  parameter int STABLE_CYC = 100,
  parameter int SAMPLE_CYC = 4,
  parameter int SEC_CYC    = 10
) (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       supply_droop_reset,
  input wire logic       sleep_request_n,
  input wire logic       motion_event,
  input wire logic       txd_out,
  input wire logic       txd_oe,
  input wire logic       motion_flag_n,
  input wire logic       motion_flag_oe,
  input wire logic       serial_mode,
  input wire logic       detect_enable,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata
);
  localparam int MAX_LOW = `HOLD_S_9 * SEC_CYC + 4;
  int unsigned low_cnt_q;
  // Counts cycles of active output since the last detection.
  always_ff @(posedge core_clk) begin
    if (sys_rst || motion_event || motion_flag_n) begin
      low_cnt_q <= 0;
    end else begin
      low_cnt_q <= low_cnt_q + 1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_asleep;
    !sleep_request_n [*6];
  endsequence
  sequence s_fire;
    $fell(motion_flag_n) && sleep_request_n;
  endsequence
  chk_read_slot: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  chk_wait_inactive: assert property (
    !detect_enable && !$past(detect_enable) && !$past(detect_enable, 2) |-> motion_flag_n)
    else $error("output active while not detecting");
  chk_sleep_idle: assert property (s_asleep |-> !detect_enable && motion_flag_n)
    else $error("detecting during sleep");
  chk_fire_cause: assert property (
    $fell(motion_flag_n) |-> $past(motion_event) || $past(motion_event, 2))
    else $error("output active without detection");
  chk_hold_min: assert property (s_fire |-> !motion_flag_n [*8])
    else $error("hold cut short");
  chk_hold_max: assert property (low_cnt_q <= MAX_LOW)
    else $error("hold longer than any step");
  chk_droop_reset: assert property (
    supply_droop_reset [*5] |-> !detect_enable && motion_flag_n)
    else $error("droop did not reset");
  chk_mode_latched: assert property (
    detect_enable && $past(detect_enable) |-> $stable(serial_mode))
    else $error("mode changed while running");
  chk_pin_hw: assert property (
    !serial_mode && !$past(serial_mode) |-> motion_flag_oe && !txd_oe)
    else $error("pin drive wrong in hardware mode");
  chk_start_bit: assert property ($fell(txd_out) && txd_oe |-> !txd_out [*8])
    else $error("start bit too short");
endmodule

bind motion_output_controller motion_ctrl_asserts #(
  .STABLE_CYC(STABLE_CYC), .SAMPLE_CYC(SAMPLE_CYC), .SEC_CYC(SEC_CYC)
) i_motion_ctrl_asserts (
  .core_clk(core_clk), .sys_rst(sys_rst), .supply_droop_reset(supply_droop_reset),
  .sleep_request_n(sleep_request_n), .motion_event(motion_event), .txd_out(txd_out),
  .txd_oe(txd_oe), .motion_flag_n(motion_flag_n), .motion_flag_oe(motion_flag_oe),
  .serial_mode(serial_mode), .detect_enable(detect_enable), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata)
);

// *** host_link_model.sv ***
// Host and load on the far side: serial link and the shared motion pin.
// Assumes the core clock of the controller and the map header.
`timescale 1ns/100ps
`include "motion_ctrl_map.svh"
module host_link_model #(
  parameter int BIT_CYC = `UART_BIT_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       txd_out,
  input  wire logic       txd_oe,
  input  wire logic       motion_flag_n,
  input  wire logic       motion_flag_oe,
  input  wire logic       pin_reset,
  input  wire logic       send,
  input  wire logic [7:0] send_data,
  output logic            rxd,
  output logic            pin_level,
  output logic [7:0]      got_data
);
  logic line_q = 1'b1;
  assign rxd = line_q;
  // Pin is pulled up when nobody drives it.
  assign pin_level = motion_flag_oe ? motion_flag_n : !pin_reset;
  // Receives one 8N1 frame, least significant bit first.
  always @(negedge txd_out) begin
    if (txd_oe) begin
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge core_clk);
        got_data[i] = txd_out;
      end
    end
  end
  // Sends one 8N1 frame when asked.
  always @(posedge core_clk) begin
    if (send) begin
      line_q <= 1'b0;
      repeat (BIT_CYC) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        line_q <= send_data[i];
        repeat (BIT_CYC) @(posedge core_clk);
      end
      line_q <= 1'b1;
    end
  end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the motion output controller.
// Assumes the package, map header, checker and host model.
`timescale 1ns/100ps
`include "motion_ctrl_map.svh"
module tb_top;
  import motion_ctrl_pkg::*;
  logic core_clk = 0, sys_rst = 1, supply_droop_reset = 0, sleep_request_n = 1;
  logic motion_event = 0, reg_wr = 0, reg_rd = 0, pin_reset = 0, send = 0;
  logic rxd, txd_out, txd_oe, pin_level, motion_flag_n, motion_flag_oe;
  logic module_reset_req, serial_mode, detect_enable;
  logic [3:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, send_data = 8'h3C, got_data;
  code_t mode_sense_in = 0, sensitivity_in = 0, hold_time_in = 0, light_level_in = 8'hFF;
  code_t sensitivity_level;
  code_t hc[4] = '{8'h00, 8'h0F, 8'h1E, 8'hFF};
  int hs[4] = '{`HOLD_S_0, `HOLD_S_1, `HOLD_S_2, `HOLD_S_9};
  int errors = 0, n_tests = 0;
  always #50 core_clk = ~core_clk;
  motion_output_controller #(.STABLE_CYC(100), .SAMPLE_CYC(4), .SEC_CYC(10)) i_motion_output_controller (
    .core_clk(core_clk), .sys_rst(sys_rst), .supply_droop_reset(supply_droop_reset),
    .sleep_request_n(sleep_request_n), .mode_sense_in(mode_sense_in), .sensitivity_in(sensitivity_in),
    .hold_time_in(hold_time_in), .light_level_in(light_level_in), .motion_event(motion_event),
    .rxd_in(rxd), .txd_out(txd_out), .txd_oe(txd_oe), .motion_flag_n_in(pin_level),
    .motion_flag_n(motion_flag_n), .motion_flag_oe(motion_flag_oe), .module_reset_req(module_reset_req),
    .sensitivity_level(sensitivity_level), .serial_mode(serial_mode), .detect_enable(detect_enable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  host_link_model i_host_link_model (.core_clk(core_clk), .txd_out(txd_out), .txd_oe(txd_oe),
    .motion_flag_n(motion_flag_n), .motion_flag_oe(motion_flag_oe), .pin_reset(pin_reset), .send(send),
    .send_data(send_data), .rxd(rxd), .pin_level(pin_level), .got_data(got_data));
  function automatic logic [7:0] b(input logic v);
    return {7'h00, v};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    check(reg_rdata, exp);
  endtask
  task automatic fire;
    @(posedge core_clk);
    motion_event <= 1'b1;
    @(posedge core_clk);
    motion_event <= 1'b0;
  endtask
  task automatic wait_run;
    for (int k = 0; k < 300 && detect_enable !== 1'b1; k++) @(posedge core_clk);
    check(b(detect_enable), 8'h01);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    stop_test();
  end
  initial begin
    cyc(3);
    sys_rst <= 1'b0;
    check(b(motion_flag_n), 8'h01);
    cyc(50);
    check({6'h00, motion_flag_n, detect_enable}, 8'h02);
    rd(`REG_LIGHT_THR, 8'h64);
    rd(`REG_CTRL, 8'h00);
    rd(4'hF, 8'h00);
    wait_run();
    check(b(serial_mode), 8'h00);
    rd(`REG_STATUS, 8'h02);
    check(sensitivity_level, 8'h8B);
    sensitivity_in <= 8'hFF;
    cyc(12);
    check(sensitivity_level, 8'h00);
    for (int i = 0; i < 4; i++) begin
      hold_time_in <= hc[i];
      cyc(12);
      fire();
      cyc(2);
      check(b(motion_flag_n), 8'h00);
      cyc(hs[i] * 10 - 4);
      check(b(motion_flag_n), 8'h00);
      cyc(8);
      check(b(motion_flag_n), 8'h01);
    end
    hold_time_in <= 8'h00;
    cyc(12);
    fire();
    cyc(15);
    fire();
    cyc(15);
    check(b(motion_flag_n), 8'h00);
    light_level_in <= 8'h4C;
    cyc(12);
    fire();
    cyc(4);
    check(b(motion_flag_n), 8'h01);
    light_level_in <= 8'h4D;
    cyc(12);
    fire();
    cyc(2);
    check(b(motion_flag_n), 8'h00);
    light_level_in <= 8'h00;
    cyc(14);
    check(b(motion_flag_n), 8'h00);
    cyc(10);
    check(b(motion_flag_n), 8'h01);
    light_level_in <= 8'hFF;
    cyc(12);
    fire();
    cyc(10);
    sleep_request_n <= 1'b0;
    cyc(8);
    check(b(motion_flag_n), 8'h01);
    fire();
    rd(`REG_STATUS, 8'h04);
    check(b(motion_flag_n), 8'h01);
    sleep_request_n <= 1'b1;
    wait_run();
    supply_droop_reset <= 1'b1;
    cyc(6);
    supply_droop_reset <= 1'b0;
    cyc(40);
    check(b(detect_enable), 8'h00);
    mode_sense_in <= 8'hC3;
    sys_rst <= 1'b1;
    cyc(3);
    sys_rst <= 1'b0;
    wait_run();
    check({5'h00, serial_mode, txd_oe, motion_flag_oe}, 8'h06);
    pin_reset <= 1'b1;
    cyc(4);
    check(b(module_reset_req), 8'h01);
    pin_reset <= 1'b0;
    wr(`REG_CTRL, 8'h01);
    wr(`REG_HOLD_SEL, 8'h00);
    wr(`REG_LIGHT_THR, 8'h80);
    light_level_in <= 8'h80;
    cyc(12);
    check(b(motion_flag_oe), 8'h01);
    fire();
    cyc(4);
    check(b(motion_flag_n), 8'h01);
    light_level_in <= 8'h81;
    cyc(12);
    fire();
    cyc(2);
    check(b(motion_flag_n), 8'h00);
    light_level_in <= 8'h00;
    cyc(14);
    check(b(motion_flag_n), 8'h00);
    wr(`REG_TX_DATA, 8'hA5);
    cyc(`UART_BIT_CYC * 11);
    check(got_data, 8'hA5);
    send <= 1'b1;
    cyc(1);
    send <= 1'b0;
    cyc(`UART_BIT_CYC * 11);
    rd(`REG_RX_DATA, 8'h3C);
    stop_test();
  end
endmodule
